// [mbe_cfg.svh]
/*
 * Timing counts and pin-cycle constants of the host controller for the
 * multiplexed-bus electrically erasable memory.
 * Assumes a 40 MHz clock; included by bare name.
 */
// Behaviour
// - host uses only the active-low select; active-high one held high
// - fetch cycles keep read/write strobes high, chip select low
// - data cycles keep fetch strobe high, drive latch/read/write
// - write: latch address, lower write strobe, drive data, rise
// - host starts every next page byte within 100us
// - all data bytes of a page share address bits 7 to 14; unlock bytes use their own addresses
// - host sends three unlock bytes before the data bytes
// - unlock and data bytes form one continuous page write
`ifndef MBE_CFG_SVH
`define MBE_CFG_SVH
`define MBE_CLK_MHZ 40
`define MBE_ALE_NS 80
`define MBE_ALE_CYC 8'((`MBE_ALE_NS * `MBE_CLK_MHZ + 999) / 1000)
`define MBE_ACCESS_NS 150
`define MBE_ACCESS_CYC 8'((`MBE_ACCESS_NS * `MBE_CLK_MHZ + 999) / 1000 + 3)
`define MBE_WR_PULSE_NS 100
`define MBE_WR_PULSE_CYC 8'((`MBE_WR_PULSE_NS * `MBE_CLK_MHZ + 999) / 1000)
`define MBE_RECOVER_CYC 8'h02
`define MBE_WINDOW_US 100
`define MBE_WINDOW_CYC (`MBE_WINDOW_US * `MBE_CLK_MHZ)
`define MBE_PROG_MS 5
`define MBE_PROG_CYC (`MBE_PROG_MS * 1000 * `MBE_CLK_MHZ)
`define MBE_UNLOCK_BYTES 9'h003
`define MBE_TOGGLE_BIT 6
`endif

// [mbe_pkg.sv]
/*
 * Types shared by the host controller files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mbe_pkg;
    typedef enum logic [1:0] {MBE_OP_READ, MBE_OP_FETCH, MBE_OP_PAGE_WRITE,
        MBE_OP_NONE} mbe_op_t;
    typedef enum logic [1:0] {MBE_RSP_OK, MBE_RSP_TIMEOUT, MBE_RSP_BAD_COUNT,
        MBE_RSP_RSVD} mbe_rsp_t;
endpackage

// [mbe_page_buf.sv]
/*
 * Page staging memory: one write port, one read port, registered read data.
 * Assumes a single clock shared with the controller.
 */
module mbe_page_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem[wr_idx] <= wr_data;
        end
        rd_data <= mem[rd_idx];
    end
endmodule

// [mbe_host.sv]
/*
 * Host controller that drives the multiplexed-bus memory through its pins:
 * data reads, program fetches, unlocked page writes and toggle polling.
 * Assumes the memory pins sit on a board net resolved by the bench from
 * shared_addr_data_pins_oe; the user side runs on the same clock.
 */
`include "mbe_cfg.svh"

module mbe_host #(
    parameter int PAGE_BYTES = 128,
    parameter int PROG_MAX_CYC = `MBE_PROG_CYC,
    parameter int WINDOW_CYC = `MBE_WINDOW_CYC,
    parameter logic [14:0] UNLOCK_ADDR0 = 15'h0000,
    parameter logic [14:0] UNLOCK_ADDR1 = 15'h0000,
    parameter logic [14:0] UNLOCK_ADDR2 = 15'h0000,
    parameter logic [7:0] UNLOCK_DATA0 = 8'h00,
    parameter logic [7:0] UNLOCK_DATA1 = 8'h00,
    parameter logic [7:0] UNLOCK_DATA2 = 8'h00
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire mbe_pkg::mbe_op_t cmd_op,
    input wire logic [14:0] cmd_addr,
    input wire logic [7:0] cmd_count,
    output logic cmd_ready,
    input wire logic load_en,
    input wire logic [6:0] load_idx,
    input wire logic [7:0] load_data,
    output logic rsp_valid,
    output mbe_pkg::mbe_rsp_t rsp_status,
    output logic [7:0] rsp_data,
    output logic addr_latch_strobe,
    output logic [6:0] upper_address_inputs,
    input wire logic [7:0] shared_addr_data_pins_in,
    output logic [7:0] shared_addr_data_pins_out,
    output logic shared_addr_data_pins_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic program_fetch_strobe_n,
    output logic chip_select_n,
    output logic chip_select
);
    import mbe_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ALE, S_HOLD, S_STB, S_END, S_WAIT}
        mbe_state_t;

    mbe_state_t state;
    mbe_state_t next_state;
    mbe_op_t op;
    logic [14:0] base;
    logic [7:0] count;
    logic [8:0] step;
    logic [7:0] ph;
    logic [17:0] prog_cnt;
    logic [12:0] wait_cnt;
    logic poll;
    logic have_prev;
    logic prev_bit;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] buf_q;

    function automatic logic [14:0] unlock_addr(input logic [8:0] s);
        unlock_addr = (s == 9'h000) ? UNLOCK_ADDR0 :
            (s == 9'h001) ? UNLOCK_ADDR1 : UNLOCK_ADDR2;
    endfunction

    function automatic logic [7:0] unlock_data(input logic [8:0] s);
        unlock_data = (s == 9'h000) ? UNLOCK_DATA0 :
            (s == 9'h001) ? UNLOCK_DATA1 : UNLOCK_DATA2;
    endfunction

    // bus-cycle decode
    wire is_write = (op == MBE_OP_PAGE_WRITE) && !poll;
    wire is_fetch = (op == MBE_OP_FETCH);
    wire in_unlock = step < `MBE_UNLOCK_BYTES;
    wire [8:0] data_step = step - `MBE_UNLOCK_BYTES;
    wire [6:0] byte_idx = data_step[6:0];
    wire [6:0] low7 = 7'(base[6:0] + byte_idx);
    // page bytes keep the upper address bits of the base
    wire [14:0] data_addr = {base[14:7], low7};
    wire [14:0] cur_addr = (is_write && in_unlock) ? unlock_addr(step) :
        (is_write ? data_addr : base);
    wire [7:0] cur_wdata = in_unlock ? unlock_data(step) : buf_q;
    wire [8:0] last_step = 9'(count) + `MBE_UNLOCK_BYTES;
    wire [8:0] step_inc = step + 9'h001;
    wire more_bytes = step_inc < last_step;
    wire [7:0] stb_len = is_write ? `MBE_WR_PULSE_CYC : `MBE_ACCESS_CYC;
    wire ph_done_ale = ph + 8'h01 >= `MBE_ALE_CYC;
    wire ph_done_stb = ph + 8'h01 >= stb_len;
    wire ph_done_end = ph + 8'h01 >= `MBE_RECOVER_CYC;
    wire in_stable = sync2 == sync3;
    wire cur_bit = sync3[`MBE_TOGGLE_BIT];
    wire poll_settled = have_prev && (cur_bit == prev_bit);
    wire prog_timeout = prog_cnt >= 18'(PROG_MAX_CYC);
    wire count_ok = (cmd_count != 8'h00) && (32'(cmd_count) <= PAGE_BYTES);
    wire cmd_take = (state == S_IDLE) && cmd_ready && cmd_valid
        && cmd_op != MBE_OP_NONE;
    wire bad_write = cmd_op == MBE_OP_PAGE_WRITE && !count_ok;
    wire rd_finish = (state == S_END) && ph_done_end;
    wire wait_done = 32'(wait_cnt) >= WINDOW_CYC;

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:
                if (cmd_take && !bad_write)
                    next_state = S_ALE;
            S_ALE:
                if (ph_done_ale)
                    next_state = S_HOLD;
            S_HOLD:
                next_state = S_STB;
            S_STB:
                if (ph_done_stb && (is_write || in_stable))
                    next_state = S_END;
            S_END:
                if (ph_done_end)
                begin
                    if (is_write)
                        next_state = more_bytes ? S_ALE : S_WAIT;
                    else if (poll && !poll_settled && !prog_timeout)
                        next_state = S_ALE;
                    else
                        next_state = S_IDLE;
                end
            S_WAIT:
                if (wait_done)
                    next_state = S_ALE;
        endcase
    end

    mbe_page_buf #(.WIDTH(8), .DEPTH(PAGE_BYTES), .AW(7)) page_buf (
        .clock(clock),
        .wr_en(load_en),
        .wr_idx(load_idx),
        .wr_data(load_data),
        .rd_idx(byte_idx),
        .rd_data(buf_q)
    );

    // pin input synchroniser
    always_ff @(posedge clock)
    begin
        sync1 <= shared_addr_data_pins_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || next_state != state)
            ph <= 8'h00;
        else if (ph != 8'hFF)
            ph <= ph + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || state != S_WAIT)
            wait_cnt <= 13'h0000;
        else
            wait_cnt <= wait_cnt + 13'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || !poll)
            prog_cnt <= 18'h00000;
        else if (!prog_timeout)
            prog_cnt <= prog_cnt + 18'h00001;
    end

    // command capture and page sequencing
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            op <= MBE_OP_NONE;
            base <= 15'h0000;
            count <= 8'h00;
            step <= 9'h000;
            poll <= 1'b0;
        end
        else if (cmd_take)
        begin
            op <= cmd_op;
            base <= cmd_addr;
            count <= cmd_count;
            step <= 9'h000;
            poll <= 1'b0;
        end
        else if (rd_finish && is_write)
        begin
            step <= more_bytes ? step_inc : step;
            poll <= !more_bytes;
        end
        else if (state == S_IDLE)
            poll <= 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || cmd_take)
        begin
            have_prev <= 1'b0;
            prev_bit <= 1'b0;
        end
        else if (rd_finish && poll)
        begin
            have_prev <= 1'b1;
            prev_bit <= cur_bit;
        end
    end

    // response
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rsp_valid <= 1'b0;
            rsp_status <= MBE_RSP_OK;
            rsp_data <= 8'h00;
        end
        else if (cmd_take && bad_write)
        begin
            rsp_valid <= 1'b1;
            rsp_status <= MBE_RSP_BAD_COUNT;
            rsp_data <= 8'h00;
        end
        else if (rd_finish && !is_write && next_state == S_IDLE)
        begin
            rsp_valid <= 1'b1;
            rsp_status <= (poll && !poll_settled) ? MBE_RSP_TIMEOUT
                : MBE_RSP_OK;
            rsp_data <= sync3;
        end
        else
            rsp_valid <= 1'b0;
    end

    // pin drive, registered from the next state
    wire n_ale = next_state == S_ALE;
    wire n_addr = n_ale || next_state == S_HOLD;
    wire n_stb = next_state == S_STB;
    wire n_wdrv = is_write && (n_stb || next_state == S_END);
    wire n_busy = next_state != S_IDLE && next_state != S_WAIT;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            addr_latch_strobe <= 1'b0;
            upper_address_inputs <= 7'h00;
            shared_addr_data_pins_out <= 8'h00;
            shared_addr_data_pins_oe <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            program_fetch_strobe_n <= 1'b1;
            chip_select_n <= 1'b1;
            chip_select <= 1'b1;
            cmd_ready <= 1'b0;
        end
        else
        begin
            addr_latch_strobe <= n_ale;
            upper_address_inputs <= cur_addr[14:8];
            shared_addr_data_pins_out <= n_addr ? cur_addr[7:0] : cur_wdata;
            shared_addr_data_pins_oe <= n_addr || n_wdrv;
            read_strobe_n <= !(n_stb && !is_write && !is_fetch);
            write_strobe_n <= !(n_stb && is_write);
            program_fetch_strobe_n <= !(n_stb && is_fetch);
            chip_select_n <= !n_busy;
            chip_select <= 1'b1;
            cmd_ready <= next_state == S_IDLE;
        end
    end
endmodule

// [mbe_host_props.sv]
/* checker of the host pin protocol and command answers
   assumes binding into mbe_host, one clock domain */
module mbe_host_props #(
    parameter int WINDOW_CYC = 4000,
    parameter int PAGE_BYTES = 128
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire mbe_pkg::mbe_op_t cmd_op,
    input wire logic [7:0] cmd_count,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire mbe_pkg::mbe_rsp_t rsp_status,
    input wire logic addr_latch_strobe,
    input wire logic shared_addr_data_pins_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic program_fetch_strobe_n,
    input wire logic chip_select_n,
    input wire logic chip_select
);
    timeunit 1ns;
    timeprecision 1ps;
    import mbe_pkg::*;
    int gap;
    logic in_page;
    wire take = cmd_valid && cmd_ready && cmd_op != MBE_OP_NONE;
    wire rd_take = take && cmd_op inside {MBE_OP_READ, MBE_OP_FETCH};
    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);
    // cycles since the last write strobe fall, and page in progress
    always_ff @(posedge clock)
    begin
        gap <= $fell(write_strobe_n) ? 0 : gap + 1;
        in_page <= !sys_rst && !rsp_valid && (in_page || !write_strobe_n);
    end
    property p_sel; chip_select; endproperty
    a_sel: assert property (p_sel)
        else $error("active-high select dropped");
    property p_fetch;
        !program_fetch_strobe_n |->
            read_strobe_n && write_strobe_n && !chip_select_n;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch strobe with other strobe or no select");
    property p_data;
        !read_strobe_n || !write_strobe_n |-> program_fetch_strobe_n
            && !chip_select_n && (read_strobe_n || write_strobe_n);
    endproperty
    a_data: assert property (p_data)
        else $error("bad data strobe combination");
    property p_latch;
        addr_latch_strobe |-> shared_addr_data_pins_oe && !chip_select_n
            && read_strobe_n && write_strobe_n && program_fetch_strobe_n;
    endproperty
    a_latch: assert property (p_latch)
        else $error("address not driven under latch strobe");
    property p_wdata;
        $rose(write_strobe_n) |->
            shared_addr_data_pins_oe ##1 shared_addr_data_pins_oe;
    endproperty
    a_wdata: assert property (p_wdata)
        else $error("write data not held at strobe rise");
    property p_fight;
        shared_addr_data_pins_oe |-> read_strobe_n && program_fetch_strobe_n;
    endproperty
    a_fight: assert property (p_fight)
        else $error("host drives pins during a read");
    property p_window;
        $fell(write_strobe_n) && in_page |-> gap < WINDOW_CYC;
    endproperty
    a_window: assert property (p_window)
        else $error("page byte gap too long");
    property p_bad;
        take && cmd_op == MBE_OP_PAGE_WRITE
            && (cmd_count == 0 || cmd_count > PAGE_BYTES)
            |=> rsp_valid && rsp_status == MBE_RSP_BAD_COUNT && chip_select_n;
    endproperty
    a_bad: assert property (p_bad)
        else $error("bad count not refused");
    property p_rd_latch;
        rd_take |=> addr_latch_strobe[*4] ##1 !addr_latch_strobe;
    endproperty
    a_rd_latch: assert property (p_rd_latch)
        else $error("read latch strobe not four cycles");
    c_read: cover property (take && cmd_op == MBE_OP_READ);
    c_fetch: cover property (take && cmd_op == MBE_OP_FETCH);
    c_ok: cover property (rsp_valid && rsp_status == MBE_RSP_OK);
endmodule
bind mbe_host mbe_host_props #(.WINDOW_CYC(WINDOW_CYC),
    .PAGE_BYTES(PAGE_BYTES)) mbe_host_props_inst (.clock(clock),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_count(cmd_count), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .addr_latch_strobe(addr_latch_strobe),
    .shared_addr_data_pins_oe(shared_addr_data_pins_oe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .program_fetch_strobe_n(program_fetch_strobe_n),
    .chip_select_n(chip_select_n), .chip_select(chip_select));

// [mbe_mem_model.sv]
/* behavioural model of the multiplexed-bus memory device
   assumes the bench resolves the shared pins from both drivers */
module mbe_mem_model #(
    parameter int ACC_NS = 140,
    parameter int WIN_NS = 1000,
    parameter int PROG_NS = 3000,
    parameter logic [14:0] UA [3] = '{15'h0000, 15'h0000, 15'h0000},
    parameter logic [7:0] UD [3] = '{8'h00, 8'h00, 8'h00}
) (
    input wire logic addr_latch_strobe,
    input wire logic [6:0] upper_address_inputs,
    input wire logic [7:0] shared_addr_data_pins,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic program_fetch_strobe_n,
    input wire logic chip_select_n,
    input wire logic chip_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [32768];
    logic [7:0] pg [int];
    logic [14:0] addr;
    logic [1:0] ulk = 2'h0;
    logic tgl = 1'b0;
    logic busy = 1'b0;
    logic rd_d;
    time t_fall = 0;
    wire sel = !chip_select_n && chip_select;
    wire rd_now = sel && (!program_fetch_strobe_n || !read_strobe_n);
    assign #(ACC_NS) rd_d = rd_now;
    assign data_oe = rd_now && rd_d;
    assign data_out = busy ? {mem[addr][7], tgl, mem[addr][5:0]} : mem[addr];
    initial foreach (mem[i]) mem[i] = 8'hFF;
    always @(negedge addr_latch_strobe)
        addr = {upper_address_inputs, shared_addr_data_pins};
    always @(posedge read_strobe_n or posedge program_fetch_strobe_n)
        if (sel && busy) tgl = !tgl;
    always @(negedge write_strobe_n)
        if (sel) t_fall = $time;
    always @(posedge write_strobe_n)
        if (sel && !busy)
        begin
            if (ulk == 2'h3) pg[addr] = shared_addr_data_pins;
            else if (addr == UA[ulk] && shared_addr_data_pins == UD[ulk])
                ulk++;
            else ulk = 2'h0;
        end
    // page closes once the window passes with no further write
    always #10
        if (ulk != 2'h0 && write_strobe_n && !busy && $time - t_fall >= WIN_NS)
        begin
            foreach (pg[a]) mem[a] = pg[a];
            pg.delete();
            busy = (ulk == 2'h3);
            ulk = 2'h0;
            if (busy) #(PROG_NS) busy = 1'b0;
        end
endmodule

// [tb.sv]
/* self-checking bench of the host controller against the memory model
   assumes design, checker and model files are compiled first */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mbe_pkg::*;
    localparam logic [14:0] UA [3] = '{15'h0123, 15'h0456, 15'h0123};
    localparam logic [7:0] UD [3] = '{8'h3C, 8'hC3, 8'h5A};
    logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, load_en = 1'b0;
    mbe_op_t cmd_op = MBE_OP_NONE;
    logic [14:0] cmd_addr = '0;
    logic [7:0] cmd_count = '0, load_data = '0, pins, h_out, m_out, rsp_data;
    logic [6:0] load_idx = '0, upper;
    logic cmd_ready, rsp_valid, ale, h_oe, m_oe, rd_n, wr_n, pf_n, cs_n, cs;
    mbe_rsp_t rsp_status;
    int failures = 0, total_checks = 0, cyc = 0;
    always #12.5 clock = !clock;
    // released pins show a pattern that changes on every clock edge, twice a cycle
    assign pins = h_oe ? h_out : m_oe ? m_out : 8'h96 ^ {8{clock}};
    mbe_host #(.PROG_MAX_CYC(400), .WINDOW_CYC(40),
        .UNLOCK_ADDR0(UA[0]), .UNLOCK_ADDR1(UA[1]), .UNLOCK_ADDR2(UA[2]),
        .UNLOCK_DATA0(UD[0]), .UNLOCK_DATA1(UD[1]), .UNLOCK_DATA2(UD[2])
    ) mbe_host_inst (.clock(clock), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_count(cmd_count), .cmd_ready(cmd_ready), .load_en(load_en),
        .load_idx(load_idx), .load_data(load_data), .rsp_valid(rsp_valid),
        .rsp_status(rsp_status), .rsp_data(rsp_data),
        .addr_latch_strobe(ale), .upper_address_inputs(upper),
        .shared_addr_data_pins_in(pins), .shared_addr_data_pins_out(h_out),
        .shared_addr_data_pins_oe(h_oe), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .program_fetch_strobe_n(pf_n),
        .chip_select_n(cs_n), .chip_select(cs));
    mbe_mem_model #(.UA(UA), .UD(UD)) mbe_mem_model_inst (
        .addr_latch_strobe(ale), .upper_address_inputs(upper),
        .shared_addr_data_pins(pins), .data_out(m_out), .data_oe(m_oe),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .program_fetch_strobe_n(pf_n), .chip_select_n(cs_n),
        .chip_select(cs));
    function automatic logic [7:0] pat(int i);
        return 8'(i * 8'h25 + 8'h11);
    endfunction
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one command, held until taken, then wait for its answer
    task automatic run(mbe_op_t op, logic [14:0] a, logic [7:0] n);
        @(negedge clock);
        while (cmd_ready !== 1'b1) @(negedge clock);
        cmd_op = op;
        cmd_addr = a;
        cmd_count = n;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge clock);
    endtask
    task automatic t_bad_count();
        run(MBE_OP_PAGE_WRITE, 15'h0100, 8'h00);
        chk("status_zero", rsp_status, MBE_RSP_BAD_COUNT);
        run(MBE_OP_PAGE_WRITE, 15'h0100, 8'h81);
        chk("status_over", rsp_status, MBE_RSP_BAD_COUNT);
    endtask
    // a no-operation request is never taken and starts no bus cycle
    task automatic t_none();
        @(negedge clock);
        cmd_op = MBE_OP_NONE;
        cmd_valid = 1'b1;
        repeat (3) @(negedge clock);
        chk("none_rsp", rsp_valid, 1'b0);
        chk("none_sel", cs_n, 1'b1);
        cmd_valid = 1'b0;
    endtask
    task automatic t_page(logic [14:0] base, int n);
        logic [14:0] a;
        for (int i = 0; i < n; i++)
        begin
            @(negedge clock);
            load_en = 1'b1;
            load_idx = 7'(i);
            load_data = pat(i);
        end
        @(negedge clock);
        load_en = 1'b0;
        run(MBE_OP_PAGE_WRITE, base, 8'(n));
        chk("wr_status", rsp_status, MBE_RSP_OK);
        for (int i = 0; i < n; i += (n > 1) ? n - 1 : 1)
        begin
            a = {base[14:7], 7'(base[6:0] + 7'(i))};
            run(MBE_OP_READ, a, 8'h00);
            chk("read", rsp_data, pat(i));
            run(MBE_OP_FETCH, a, 8'h00);
            chk("fetch", rsp_data, pat(i));
        end
        run(MBE_OP_READ, base ^ 15'h0080, 8'h00);
        chk("other_page", rsp_data, 8'hFF);
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            end_sim();
        end
    end
    initial
    begin
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        t_bad_count();
        t_none();
        t_page(15'h0AFE, 128);
        t_page(15'h7FFF, 1);
        end_sim();
    end
endmodule
